// ---- shared/cpi2c_defines.svh ----
// constants of the control port front end: offsets, field positions, reset values, counts
// assumes a single 25 MHz clock domain and a combinational location decoder outside
//
// Overview of operation
// - boot select low at power-up gives two-wire control mode by default
// - three low pulses on the latch pin move two-wire mode into four-wire mode
// - boot select high at power-up hands startup to the external memory loader
// - every location can be read and written; read-only locations ignore writes
// - any location is reached by one word or a burst of consecutive words
// - first byte holds seven-bit chip address then the direction bit
// - second and third bytes form the sixteen-bit location address
// - data starts at fourth byte; bytes per word follow the addressed location
// - control-port command can halt the core output and later restart it
// - buffered parameter set is moved into the program within one audio frame
// - in two-wire mode the block is slave only and never starts a transfer
// - address byte is 01110, high strap, low strap, direction: 0x70 to 0x77
// - direction bit one means read from device, zero means write to it
// - after power-up rest idle, watching the lines for start and own address
// - start is data falling while clock high; the block detects it
// - after start shift in eight bits msb first as address and direction
// - on address match pull data low during the ninth clock pulse
// - stop is data rising while clock high and ends the transfer
// - bursts advance the location after each whole word of one to five bytes; read bursts hold at 0xffff
// - invalid location address gets no acknowledge and a return to idle
`ifndef CPI2C_DEFINES_SVH
`define CPI2C_DEFINES_SVH

`define CPI2C_ADDR_FIXED      5'h0e
`define CPI2C_LATCH_PULSES    2'h3
`define CPI2C_SETTLE_CYCLES   2'h3
`define CPI2C_BITS_PER_BYTE   4'h8
`define CPI2C_MAX_WORD_BYTES  3'h5
`define CPI2C_RESET_SUBADDR   16'h0000
`define CPI2C_TOP_SUBADDR     16'hffff
`define CPI2C_CORE_CTRL_ADDR  16'hf000
`define CPI2C_CORE_HALT_BIT   0
`define CPI2C_SAFE_SLOT0_ADDR 16'hf001
`define CPI2C_SAFE_SLOTS      3'h5
`define CPI2C_SAFE_TGT_ADDR   16'hf006
`define CPI2C_SAFE_GO_ADDR    16'hf007

`endif

// ---- shared/cpi2c_pkg.sv ----
// types of the control port front end
// assumes cpi2c_defines.svh is on the include path
`include "cpi2c_defines.svh"

package cpi2c_pkg;

	typedef enum logic [3:0] {
		MODE_INIT = 4'h1,
		MODE_I2C  = 4'h2,
		MODE_SPI  = 4'h4,
		MODE_BOOT = 4'h8
	} cpi2c_mode_t;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RX   = 6'h02,
		ST_ACK  = 6'h04,
		ST_LOAD = 6'h08,
		ST_TX   = 6'h10,
		ST_RACK = 6'h20
	} cpi2c_bus_st_t;

	typedef enum logic [3:0] {
		PH_ADDR  = 4'h1,
		PH_SUBHI = 4'h2,
		PH_SUBLO = 4'h4,
		PH_DATA  = 4'h8
	} cpi2c_phase_t;

	typedef struct packed {
		cpi2c_mode_t         mode;
		logic [1:0]          settle;
		logic [1:0]          latch_cnt;
		logic                scl_prev;
		logic                sda_prev;
		logic                latch_prev;
		cpi2c_bus_st_t       st;
		cpi2c_phase_t        phase;
		logic                to_tx;
		logic                ack_ok;
		logic [3:0]          bitcnt;
		logic [7:0]          shift;
		logic                sda_oe;
		logic [15:0]         addr;
		logic [2:0]          bytecnt;
		logic [31:0]         wbuf;
		logic                wr_strobe;
		logic [15:0]         wr_addr;
		logic [39:0]         wr_data;
		logic [2:0]          wr_len;
		logic                core_halt;
		logic [4:0][39:0]    slots;
		logic [15:0]         safe_tgt;
		logic [2:0]          safe_count;
		logic [2:0]          safe_idx;
		logic                safe_pend;
		logic                safe_busy;
		logic                safe_we;
		logic [15:0]         safe_addr;
		logic [39:0]         safe_data;
	} cpi2c_state_t;

	typedef struct packed {
		logic meta;
		logic stable;
	} cpi2c_sync_t;

endpackage : cpi2c_pkg

// ---- hdl/cpi2c_sync.sv ----
// two-flop synchroniser for one pin
// assumes the pin is asynchronous to clk_in
`timescale 1ns/1ps
`default_nettype none

module cpi2c_sync (
	input  wire logic clk_in,
	input  wire logic reset_in,
	input  wire logic d_in,
	output logic      q_out
);

	cpi2c_pkg::cpi2c_sync_t r_reg;
	cpi2c_pkg::cpi2c_sync_t r_next;

	always_comb begin
		r_next = r_reg;
		r_next.meta = d_in;
		r_next.stable = r_reg.meta;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign q_out = r_reg.stable;

endmodule : cpi2c_sync

`default_nettype wire

// ---- hdl/cpi2c_slave.sv ----
// control port front end: mode select, two-wire slave, word assembly, core halt, safe load
// assumes a combinational location decoder on mem_addr_out that returns length, read-only
// flag and the read byte selected by mem_byte_out, all on clk_in
`timescale 1ns/1ps
`default_nettype none
`include "cpi2c_defines.svh"

module cpi2c_slave (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	input  wire logic        spi_latch_pin_in,
	input  wire logic        boot_source_select_in,
	input  wire logic        address_strap_low_in,
	input  wire logic        address_strap_high_in,
	input  wire logic [2:0]  loc_len_in,
	input  wire logic        loc_ro_in,
	input  wire logic [7:0]  rd_data_in,
	input  wire logic        frame_start_in,
	output logic             sda_out,
	output logic             sda_oe_out,
	output logic [15:0]      mem_addr_out,
	output logic [2:0]       mem_byte_out,
	output logic             wr_strobe_out,
	output logic [15:0]      wr_addr_out,
	output logic [39:0]      wr_data_out,
	output logic [2:0]       wr_len_out,
	output logic             core_halt_out,
	output logic             safe_we_out,
	output logic [15:0]      safe_addr_out,
	output logic [39:0]      safe_data_out,
	output logic             i2c_mode_out,
	output logic             spi_mode_out,
	output logic             self_boot_out
);

	cpi2c_pkg::cpi2c_state_t r_reg;
	cpi2c_pkg::cpi2c_state_t r_next;

	logic scl_s;
	logic sda_s;
	logic latch_s;
	logic boot_s;
	logic strap_lo_s;
	logic strap_hi_s;

	cpi2c_sync u_sync_scl (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.d_in     (scl_in),
		.q_out    (scl_s)
	);

	cpi2c_sync u_sync_sda (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.d_in     (sda_in),
		.q_out    (sda_s)
	);

	cpi2c_sync u_sync_latch (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.d_in     (spi_latch_pin_in),
		.q_out    (latch_s)
	);

	cpi2c_sync u_sync_boot (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.d_in     (boot_source_select_in),
		.q_out    (boot_s)
	);

	cpi2c_sync u_sync_strap_lo (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.d_in     (address_strap_low_in),
		.q_out    (strap_lo_s)
	);

	cpi2c_sync u_sync_strap_hi (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.d_in     (address_strap_high_in),
		.q_out    (strap_hi_s)
	);

	logic        scl_rise;
	logic        scl_fall;
	logic        start_seen;
	logic        stop_seen;
	logic [7:0]  rx_byte;
	logic [39:0] word;
	logic [2:0]  rd_len;
	logic [15:0] slot_off;

	always_comb begin
		r_next = r_reg;
		scl_rise = scl_s & ~r_reg.scl_prev;
		scl_fall = ~scl_s & r_reg.scl_prev;
		start_seen = scl_s & r_reg.scl_prev & r_reg.sda_prev & ~sda_s;
		stop_seen = scl_s & r_reg.scl_prev & ~r_reg.sda_prev & sda_s;
		rx_byte = {r_reg.shift[6:0], sda_s};
		word = {r_reg.wbuf, r_reg.shift};
		rd_len = (loc_len_in == 3'h0) ? 3'h1 : loc_len_in;
		slot_off = r_reg.wr_addr - `CPI2C_SAFE_SLOT0_ADDR;
		r_next.scl_prev = scl_s;
		r_next.sda_prev = sda_s;
		r_next.latch_prev = latch_s;
		r_next.wr_strobe = 1'b0;
		r_next.safe_we = 1'b0;

		unique case (r_reg.mode)
			cpi2c_pkg::MODE_INIT: begin
				// strap is read only once the synchroniser has settled after reset
				r_next.settle = r_reg.settle + 2'h1;
				if (r_reg.settle == `CPI2C_SETTLE_CYCLES) begin
					if (boot_s) begin
						r_next.mode = cpi2c_pkg::MODE_BOOT;
					end else begin
						r_next.mode = cpi2c_pkg::MODE_I2C;
					end
				end
			end
			cpi2c_pkg::MODE_I2C: begin
				if (r_reg.latch_prev & ~latch_s) begin
					r_next.latch_cnt = r_reg.latch_cnt + 2'h1;
					if (r_reg.latch_cnt + 2'h1 == `CPI2C_LATCH_PULSES) begin
						r_next.mode = cpi2c_pkg::MODE_SPI;
					end
				end
			end
			cpi2c_pkg::MODE_SPI: begin
			end
			cpi2c_pkg::MODE_BOOT: begin
			end
		endcase

		if (r_reg.mode != cpi2c_pkg::MODE_I2C) begin
			r_next.st = cpi2c_pkg::ST_IDLE;
			r_next.sda_oe = 1'b0;
		end else if (start_seen) begin
			r_next.st = cpi2c_pkg::ST_RX;
			r_next.phase = cpi2c_pkg::PH_ADDR;
			r_next.bitcnt = 4'h0;
			r_next.sda_oe = 1'b0;
		end else if (stop_seen) begin
			r_next.st = cpi2c_pkg::ST_IDLE;
			r_next.sda_oe = 1'b0;
		end else begin
			unique case (r_reg.st)
				cpi2c_pkg::ST_IDLE: begin
					r_next.sda_oe = 1'b0;
				end
				cpi2c_pkg::ST_RX: begin
					if (scl_rise && r_reg.bitcnt != `CPI2C_BITS_PER_BYTE) begin
						r_next.shift = rx_byte;
						r_next.bitcnt = r_reg.bitcnt + 4'h1;
						// low address byte lands before the ack decision
						if (r_reg.bitcnt == `CPI2C_BITS_PER_BYTE - 4'h1 &&
						    r_reg.phase == cpi2c_pkg::PH_SUBLO) begin
							r_next.addr[7:0] = rx_byte;
						end
					end else if (scl_fall && r_reg.bitcnt == `CPI2C_BITS_PER_BYTE) begin
						r_next.bitcnt = 4'h0;
						r_next.to_tx = 1'b0;
						r_next.st = cpi2c_pkg::ST_ACK;
						r_next.sda_oe = 1'b1;
						unique case (r_reg.phase)
							cpi2c_pkg::PH_ADDR: begin
								if (r_reg.shift[7:1] ==
								    {`CPI2C_ADDR_FIXED, strap_hi_s, strap_lo_s}) begin
									r_next.to_tx = r_reg.shift[0];
									r_next.bytecnt = 3'h0;
									r_next.phase = cpi2c_pkg::PH_SUBHI;
								end else begin
									r_next.st = cpi2c_pkg::ST_IDLE;
									r_next.sda_oe = 1'b0;
								end
							end
							cpi2c_pkg::PH_SUBHI: begin
								r_next.addr[15:8] = r_reg.shift;
								r_next.phase = cpi2c_pkg::PH_SUBLO;
							end
							cpi2c_pkg::PH_SUBLO: begin
								if (loc_len_in == 3'h0) begin
									r_next.st = cpi2c_pkg::ST_IDLE;
									r_next.sda_oe = 1'b0;
								end else begin
									r_next.phase = cpi2c_pkg::PH_DATA;
									r_next.bytecnt = 3'h0;
									// a word cut short by a stop must not leak into this one
									r_next.wbuf = 32'h0000_0000;
								end
							end
							cpi2c_pkg::PH_DATA: begin
								if (loc_len_in == 3'h0) begin
									r_next.st = cpi2c_pkg::ST_IDLE;
									r_next.sda_oe = 1'b0;
								end else if (r_reg.bytecnt + 3'h1 == loc_len_in) begin
									r_next.wr_strobe = ~loc_ro_in;
									r_next.wr_addr = r_reg.addr;
									r_next.wr_data = word;
									r_next.wr_len = loc_len_in;
									r_next.addr = r_reg.addr + 16'h0001;
									r_next.bytecnt = 3'h0;
									r_next.wbuf = 32'h0000_0000;
								end else begin
									r_next.wbuf = word[31:0];
									r_next.bytecnt = r_reg.bytecnt + 3'h1;
								end
							end
						endcase
					end
				end
				cpi2c_pkg::ST_ACK: begin
					if (scl_fall) begin
						r_next.sda_oe = 1'b0;
						r_next.st = r_reg.to_tx ? cpi2c_pkg::ST_LOAD : cpi2c_pkg::ST_RX;
					end
				end
				cpi2c_pkg::ST_LOAD: begin
					// decoder answers one cycle after the address moved
					r_next.shift = rd_data_in;
					r_next.sda_oe = ~rd_data_in[7];
					r_next.bitcnt = 4'h0;
					r_next.st = cpi2c_pkg::ST_TX;
				end
				cpi2c_pkg::ST_TX: begin
					if (scl_fall) begin
						r_next.bitcnt = r_reg.bitcnt + 4'h1;
						r_next.shift = {r_reg.shift[6:0], 1'b0};
						r_next.sda_oe = ~r_reg.shift[6];
						if (r_reg.bitcnt + 4'h1 == `CPI2C_BITS_PER_BYTE) begin
							r_next.sda_oe = 1'b0;
							r_next.ack_ok = 1'b0;
							r_next.st = cpi2c_pkg::ST_RACK;
						end
					end
				end
				cpi2c_pkg::ST_RACK: begin
					if (scl_rise) begin
						r_next.ack_ok = ~sda_s;
						if (sda_s) begin
							r_next.st = cpi2c_pkg::ST_IDLE;
						end
					end else if (scl_fall && r_reg.ack_ok) begin
						r_next.st = cpi2c_pkg::ST_LOAD;
						if (r_reg.bytecnt + 3'h1 >= rd_len) begin
							r_next.bytecnt = 3'h0;
							// top location repeats until the master refuses
							if (r_reg.addr != `CPI2C_TOP_SUBADDR) begin
								r_next.addr = r_reg.addr + 16'h0001;
							end
						end else begin
							r_next.bytecnt = r_reg.bytecnt + 3'h1;
						end
					end
				end
			endcase
		end

		if (r_reg.wr_strobe && r_reg.wr_addr == `CPI2C_CORE_CTRL_ADDR) begin
			r_next.core_halt = r_reg.wr_data[`CPI2C_CORE_HALT_BIT];
		end
		if (r_reg.wr_strobe && slot_off < {13'h0000, `CPI2C_SAFE_SLOTS}) begin
			r_next.slots[slot_off[2:0]] = r_reg.wr_data;
		end
		if (r_reg.wr_strobe && r_reg.wr_addr == `CPI2C_SAFE_TGT_ADDR) begin
			r_next.safe_tgt = r_reg.wr_data[15:0];
		end

		if (r_reg.safe_busy) begin
			r_next.safe_we = 1'b1;
			r_next.safe_addr = r_reg.safe_tgt + {13'h0000, r_reg.safe_idx};
			r_next.safe_data = r_reg.slots[r_reg.safe_idx];
			r_next.safe_idx = r_reg.safe_idx + 3'h1;
			if (r_reg.safe_idx + 3'h1 == r_reg.safe_count) begin
				r_next.safe_busy = 1'b0;
			end
		end else if (r_reg.safe_pend && frame_start_in) begin
			r_next.safe_pend = 1'b0;
			r_next.safe_busy = 1'b1;
			r_next.safe_idx = 3'h0;
		end
		// a new request wins over the one being taken
		if (r_reg.wr_strobe && r_reg.wr_addr == `CPI2C_SAFE_GO_ADDR) begin
			r_next.safe_pend = 1'b1;
			if (r_reg.wr_data[2:0] == 3'h0 || r_reg.wr_data[2:0] > `CPI2C_SAFE_SLOTS) begin
				r_next.safe_count = `CPI2C_SAFE_SLOTS;
			end else begin
				r_next.safe_count = r_reg.wr_data[2:0];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			r_reg <= '0;
			r_reg.mode <= cpi2c_pkg::MODE_INIT;
			r_reg.st <= cpi2c_pkg::ST_IDLE;
			r_reg.phase <= cpi2c_pkg::PH_ADDR;
			r_reg.addr <= `CPI2C_RESET_SUBADDR;
			r_reg.scl_prev <= 1'b1;
			r_reg.sda_prev <= 1'b1;
			r_reg.latch_prev <= 1'b1;
			r_reg.safe_count <= `CPI2C_SAFE_SLOTS;
		end else begin
			r_reg <= r_next;
		end
	end

	// only the data line is ever pulled, never the clock
	assign sda_out = 1'b0;
	assign sda_oe_out = r_reg.sda_oe;
	assign mem_addr_out = r_reg.addr;
	assign mem_byte_out = r_reg.bytecnt;
	assign wr_strobe_out = r_reg.wr_strobe;
	assign wr_addr_out = r_reg.wr_addr;
	assign wr_data_out = r_reg.wr_data;
	assign wr_len_out = r_reg.wr_len;
	assign core_halt_out = r_reg.core_halt;
	assign safe_we_out = r_reg.safe_we;
	assign safe_addr_out = r_reg.safe_addr;
	assign safe_data_out = r_reg.safe_data;
	assign i2c_mode_out = (r_reg.mode == cpi2c_pkg::MODE_I2C);
	assign spi_mode_out = (r_reg.mode == cpi2c_pkg::MODE_SPI);
	assign self_boot_out = (r_reg.mode == cpi2c_pkg::MODE_BOOT);

endmodule : cpi2c_slave

`default_nettype wire

// ---- testbench/cpi2c_slave_monitor.sv ----
// concurrent checks on the control port front end ports
// assumes one clk_in domain; bound to cpi2c_slave from tb_top
`timescale 1ns/1ps
`default_nettype none
module cpi2c_slave_monitor (
	input wire logic        clk_in,
	input wire logic        reset_in,
	input wire logic        frame_start_in,
	input wire logic        sda_oe_out,
	input wire logic [15:0] mem_addr_out,
	input wire logic        wr_strobe_out,
	input wire logic [15:0] wr_addr_out,
	input wire logic [39:0] wr_data_out,
	input wire logic [2:0]  wr_len_out,
	input wire logic        core_halt_out,
	input wire logic        safe_we_out,
	input wire logic [15:0] safe_addr_out,
	input wire logic        i2c_mode_out,
	input wire logic        spi_mode_out,
	input wire logic        self_boot_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// counts the current run of safe writes; a sixth shows up as 6
	logic [2:0] run_reg;
	always_ff @(posedge clk_in) begin
		run_reg <= (reset_in || !safe_we_out) ? 3'h0 : run_reg + 3'h1;
	end
	a_mode_onehot: assert property ($onehot0({i2c_mode_out, spi_mode_out, self_boot_out}))
		else $error("two control modes at once");
	a_spi_sticky: assert property (spi_mode_out |=> spi_mode_out)
		else $error("four-wire mode left");
	a_slave_only: assert property (!i2c_mode_out |-> !sda_oe_out)
		else $error("data pulled outside two-wire mode");
	a_ack_hold: assert property ($rose(sda_oe_out) |=> sda_oe_out [*4])
		else $error("data pull released too early");
	a_strobe_pulse: assert property (wr_strobe_out |=> !wr_strobe_out)
		else $error("write strobe longer than one cycle");
	a_burst_incr: assert property (wr_strobe_out && wr_addr_out != 16'hffff
		|-> mem_addr_out == wr_addr_out + 16'h0001)
		else $error("location not advanced after word");
	a_word_len: assert property (wr_strobe_out |-> wr_len_out inside {[3'h1:3'h5]}
		&& (wr_data_out >> {wr_len_out, 3'h0}) == 40'h0)
		else $error("word length or alignment wrong");
	a_halt_follow: assert property (wr_strobe_out && wr_addr_out == 16'hf000
		|=> core_halt_out == wr_data_out[0])
		else $error("halt not taken from control word");
	a_safe_after: assert property ($rose(safe_we_out) |-> $past(frame_start_in)
		|| $past(frame_start_in, 2) || $past(frame_start_in, 3))
		else $error("safe write not tied to frame start");
	a_safe_seq: assert property (safe_we_out && $past(safe_we_out)
		|-> safe_addr_out == $past(safe_addr_out) + 16'h0001)
		else $error("safe target not consecutive");
	a_safe_count: assert property (run_reg <= 3'h5)
		else $error("more than five safe writes");
	c_long_word: cover property (wr_strobe_out && wr_len_out == 3'h5);
	c_spi_entry: cover property ($rose(spi_mode_out));
	c_safe_run: cover property (safe_we_out ##1 safe_we_out);
endmodule : cpi2c_slave_monitor
`default_nettype wire

// ---- testbench/cpi2c_bus_master.sv ----
// behavioural two-wire bus master, one bit every 320 ns
// assumes pull-ups: sda_in is the resolved wire level
`timescale 1ns/1ps
`default_nettype none
module cpi2c_bus_master (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out = 1'b1,
	output logic      sda_low_out = 1'b0
);
	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask : wt
	task automatic start();
		sda_low_out <= 1'b0;
		wt(2);
		scl_out <= 1'b1;
		wt(4);
		sda_low_out <= 1'b1;
		wt(4);
		scl_out <= 1'b0;
		wt(2);
	endtask : start
	task automatic stop();
		sda_low_out <= 1'b1;
		wt(2);
		scl_out <= 1'b1;
		wt(4);
		sda_low_out <= 1'b0;
		wt(4);
	endtask : stop
	// sample late in the high phase: the slave only moves data after a fall
	task automatic bit_io(input logic b, output logic r);
		sda_low_out <= !b;
		wt(2);
		scl_out <= 1'b1;
		wt(3);
		r = sda_in;
		wt(1);
		scl_out <= 1'b0;
		wt(2);
	endtask : bit_io
	// msb first, ninth pulse carries the acknowledge
	task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q,
		output logic got);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(!ack, got);
		got = !got;
	endtask : xfer
endmodule : cpi2c_bus_master
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the control port front end
// assumes the master model and the monitor are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "cpi2c_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
	logic        clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        latch = 1'b1;
	logic        boot = 1'b0;
	logic [1:0]  strap = 2'h0;
	logic        frame = 1'b0;
	logic        scl;
	logic        mst_low;
	wire  logic  sda;
	logic [2:0]  loc_len;
	logic        loc_ro;
	logic [7:0]  rd_byte;
	logic        oe;
	logic        strobe;
	logic        halt;
	logic        safe_we;
	logic        m_i2c;
	logic        m_spi;
	logic        m_boot;
	logic [15:0] mem_addr;
	logic [15:0] wr_addr;
	logic [15:0] safe_addr;
	logic [2:0]  mem_byte;
	logic [2:0]  wr_len;
	logic [39:0] wr_data;
	logic [39:0] safe_data;
	logic [31:0] rs = 32'h0000000d;
	int          n_mismatch = 0;
	int          n_tests = 0;
	logic [58:0] exp_wr[$];
	logic [55:0] exp_safe[$];
	logic [39:0] wlog[8];
	logic [6:0]  dev;
	logic [2:0]  cnt;
	logic        ack;
	logic [7:0]  q;
	logic [58:0] exp_w;
	logic [55:0] exp_s;
	always #20 clk_in = ~clk_in;
	assign sda = !(mst_low || oe);
	cpi2c_bus_master mst_u (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(mst_low));
	cpi2c_slave dut_u (.clk_in(clk_in), .reset_in(reset_in), .scl_in(scl), .sda_in(sda),
		.spi_latch_pin_in(latch), .boot_source_select_in(boot),
		.address_strap_low_in(strap[0]), .address_strap_high_in(strap[1]),
		.loc_len_in(loc_len), .loc_ro_in(loc_ro), .rd_data_in(rd_byte),
		.frame_start_in(frame), .sda_out(), .sda_oe_out(oe), .mem_addr_out(mem_addr),
		.mem_byte_out(mem_byte), .wr_strobe_out(strobe), .wr_addr_out(wr_addr),
		.wr_data_out(wr_data), .wr_len_out(wr_len), .core_halt_out(halt),
		.safe_we_out(safe_we), .safe_addr_out(safe_addr), .safe_data_out(safe_data),
		.i2c_mode_out(m_i2c), .spi_mode_out(m_spi), .self_boot_out(m_boot));
	function automatic logic [2:0] len_of(input logic [15:0] a);
		if (a[15:8] == 8'h80) return 3'h0;
		if (a == `CPI2C_CORE_CTRL_ADDR || a == `CPI2C_SAFE_GO_ADDR) return 3'h1;
		if (a == `CPI2C_SAFE_TGT_ADDR) return 3'h2;
		if (a[15:12] == 4'hf) return 3'h5;
		return 3'(a % 16'h0005) + 3'h1;
	endfunction : len_of
	function automatic logic [7:0] byte_of(input logic [15:0] a, input logic [2:0] b);
		return a[7:0] ^ {5'h0, b} ^ 8'h5a;
	endfunction : byte_of
	function automatic logic [7:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs[7:0];
	endfunction : rnd
	always_comb begin
		loc_len = len_of(mem_addr);
		loc_ro = (mem_addr[15:12] == 4'h4);
		rd_byte = byte_of(mem_addr, mem_byte);
	end
	// x sentinel so a strobe nobody expected never matches
	// pop once: the check macro names its expected value twice
	always @(posedge clk_in) begin
		if (strobe === 1'b1) begin
			exp_w = exp_wr.size() ? exp_wr.pop_front() : 'x;
			`CHK({wr_len, wr_addr, wr_data}, exp_w)
		end
		if (safe_we === 1'b1) begin
			exp_s = exp_safe.size() ? exp_safe.pop_front() : 'x;
			`CHK({safe_addr, safe_data}, exp_s)
		end
	end
	task automatic hdr(input logic [7:0] b0);
		mst_u.start();
		mst_u.xfer(b0, 1'b0, q, ack);
	endtask : hdr
	// burst of whole words, expectation queued before the last byte
	task automatic wr(input logic [15:0] a, input int nw, input logic keep);
		logic [39:0] d;
		logic [2:0]  n;
		hdr({dev, 1'b0});
		`CHK(ack, 1'b1)
		mst_u.xfer(a[15:8], 1'b0, q, ack);
		mst_u.xfer(a[7:0], 1'b0, q, ack);
		`CHK(ack, 1'b1)
		for (int w = 0; w < nw; w++) begin
			n = len_of(a);
			d = 40'h0;
			for (int i = 0; i < int'(n); i++) d = {d[31:0], rnd()};
			if (keep) exp_wr.push_back({n, a, d});
			wlog[w] = d;
			for (int i = int'(n) - 1; i >= 0; i--) begin
				mst_u.xfer(d[8*i +: 8], 1'b0, q, ack);
				`CHK(ack, 1'b1)
			end
			a++;
		end
		mst_u.stop();
	endtask : wr
	// subaddress set by a write header, then repeated start for reading
	task automatic rd(input logic [15:0] a, input int nb);
		logic [2:0] b;
		hdr({dev, 1'b0});
		mst_u.xfer(a[15:8], 1'b0, q, ack);
		mst_u.xfer(a[7:0], 1'b0, q, ack);
		hdr({dev, 1'b1});
		`CHK(ack, 1'b1)
		b = 3'h0;
		for (int k = 0; k < nb; k++) begin
			mst_u.xfer(8'hff, k < nb - 1, q, ack);
			`CHK(q, byte_of(a, b))
			b++;
			if (b == len_of(a)) begin
				b = 3'h0;
				a++;
			end
		end
		mst_u.stop();
	endtask : rd
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	// about eleven thousand cycles expected; fifty thousand is a hang
	initial begin
		#2000000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		repeat (6) @(posedge clk_in);
		reset_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		`CHK({m_i2c, m_spi, m_boot}, 3'h4)
		// each strap setting against each address
		for (int s = 0; s < 4; s++) begin
			strap <= 2'(s);
			for (int k = 0; k < 4; k++) begin
				dev = {`CPI2C_ADDR_FIXED, 2'(k)};
				hdr({dev, 1'b0});
				mst_u.stop();
				`CHK(ack, 1'(k == s))
			end
		end
		for (int t = 0; t < 6; t++) begin
			wr({4'h1, 4'(rnd()), rnd()}, 1 + t % 3, 1'b1);
		end
		wr(16'h4003, 2, 1'b0);
		hdr({dev, 1'b0});
		mst_u.xfer(8'h80, 1'b0, q, ack);
		mst_u.xfer(rnd(), 1'b0, q, ack);
		mst_u.stop();
		`CHK(ack, 1'b0)
		rd({4'h2, 4'(rnd()), rnd()}, 7);
		rd(16'h2ffe, 9);
		for (int t = 0; t < 2; t++) begin
			wr(`CPI2C_CORE_CTRL_ADDR, 1, 1'b1);
			`CHK(halt, wlog[0][0])
		end
		// slots, target and go in one burst, then a frame pulse
		wr(`CPI2C_SAFE_SLOT0_ADDR, 7, 1'b1);
		cnt = (wlog[6][2:0] == 3'h0 || wlog[6][2:0] > 3'h5) ? 3'h5 : wlog[6][2:0];
		for (int i = 0; i < int'(cnt); i++) exp_safe.push_back({wlog[5][15:0] + 16'(i), wlog[i]});
		frame <= 1'b1;
		@(posedge clk_in);
		frame <= 1'b0;
		repeat (12) @(posedge clk_in);
		`CHK(exp_safe.size(), 0)
		`CHK(exp_wr.size(), 0)
		repeat (3) begin
			latch <= 1'b0;
			repeat (3) @(posedge clk_in);
			latch <= 1'b1;
			repeat (3) @(posedge clk_in);
		end
		repeat (4) @(posedge clk_in);
		`CHK({m_i2c, m_spi}, 2'h1)
		hdr({dev, 1'b0});
		mst_u.stop();
		`CHK(ack, 1'b0)
		boot <= 1'b1;
		reset_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		reset_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		`CHK({m_i2c, m_spi, m_boot}, 3'h1)
		print_verdict();
	end
endmodule : tb_top
bind cpi2c_slave cpi2c_slave_monitor mon_u (.clk_in(clk_in), .reset_in(reset_in),
	.frame_start_in(frame_start_in), .sda_oe_out(sda_oe_out), .mem_addr_out(mem_addr_out),
	.wr_strobe_out(wr_strobe_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out),
	.wr_len_out(wr_len_out), .core_halt_out(core_halt_out), .safe_we_out(safe_we_out),
	.safe_addr_out(safe_addr_out), .i2c_mode_out(i2c_mode_out),
	.spi_mode_out(spi_mode_out), .self_boot_out(self_boot_out));
`default_nettype wire
